//--- ramped_pulse_defines.svh
// Constants of the ramped pulse train generator: register map, fields, limits, timing
// How it works
// - Start ramps frequency up, holds target, ramps down, stops at exact count.
// - Commanded frequency below six hertz runs at six hertz.
// - Frequency above channel maximum is clamped to that maximum.
// - Fast outputs start and end at their channel edge frequency register.
// - Slow outputs ramp from zero and back to zero frequency.
// - Format zero gives two pulse lines; format one gives pulse plus direction.
// - Slow outputs and unsplit fast outputs share one up and down time.
// - Split flag on: ramp operand is up time, down time from register.
// - Fast outputs use linear or S ramp by flag; slow always linear.
// - Frequency, count and ramp time are latched at start.
// - Completion flag set when pulse-direction output ends, cleared on restart.
// - Extra pulses are filled so the emitted total equals the count.
// - Four operations at once; a shared slow pin goes to the first driver.
// - Dropping run stops at once; restart continues from the present count.
// - Pause flag on ramps down and pauses; off resumes remaining pulses.
// - With mark enabled, a sensor edge starts a ramp-down pause.
// - Mark stop count raised to fit down time, kept below half the total.
// - Mark stop count is 32 bits; zero disables the mark function.
// - Nonzero mask count ignores marks until that many pulses are out.
// - Mark stop sets the paused status; clearing pause resumes output.
`ifndef RAMPED_PULSE_DEFINES_SVH
`define RAMPED_PULSE_DEFINES_SVH

`define CLK_HZ        32'h02625A00
`define MS_PER_S      32'h000003E8

`define F_MIN         17'h00006
`define F_MAX_SLOW    17'h02710
`define F_MAX_FAST16  17'h07FFF
`define F_MAX_FAST32  17'h186A0
`define T_MIN         16'h0014
`define STEPS_FAST    5'h14
`define STEPS_SLOW    5'h0A

`define REG_RESET     16'h0000

// Operation blocks at 0x00, 0x10, 0x20, 0x30: fast_a, slow_a, fast_b, slow_b
`define OFS_FREQ_LO   4'h0
`define OFS_FREQ_HI   4'h1
`define OFS_CNT_LO    4'h2
`define OFS_CNT_HI    4'h3
`define OFS_RAMP      4'h4
`define OFS_CTRL      4'h5
`define OFS_PRES_LO   4'h6
`define OFS_PRES_HI   4'h7
`define OFS_STAT      4'h8

`define CTRL_RUN      0
`define CTRL_WIDE     1
`define CTRL_PAUSE    2
`define STAT_BUSY     0
`define STAT_PAUSED   1
`define STAT_DIR      2

// Channel blocks at 0x40 and 0x50
`define CH_BASE       3'h2
`define OFS_FMT       4'h0
`define OFS_EDGE      4'h1
`define OFS_DOWN_T    4'h2
`define OFS_MASK_LO   4'h3
`define OFS_MASK_HI   4'h4
`define OFS_MSTOP_LO  4'h5
`define OFS_MSTOP_HI  4'h6
`define OFS_CH_FLAGS  4'h7
`define OFS_CH_STAT   4'h8
`define FLAG_SPLIT    0
`define FLAG_MARK_EN  1
`define CHST_DONE     0
`define CHST_MPAUSED  1

`define ADDR_GLOBAL   8'h60
`define GLB_SCURVE    0

`endif

//--- ramped_pulse_pkg.sv
// Types shared by the ramped pulse train generator
package ramped_pulse_pkg;

	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_UP,
		ST_HOLD,
		ST_DOWN,
		ST_FILL,
		ST_PAUSED
	} engine_state_t;

	typedef struct packed
	{
		logic [16:0] tgt;
		logic [16:0] edge_f;
		logic [16:0] fill;
		logic [15:0] tup;
		logic [15:0] tdn;
		logic        s_curve;
		logic        dir_fmt;
		logic        dir_own;
		logic        fwd;
	} op_latch_t;

endpackage

//--- pulse_nco.sv
// Phase accumulator that turns a frequency in hertz into a square pulse train
`timescale 1ns/100ps
`include "ramped_pulse_defines.svh"

module pulse_nco #(
	parameter int CLK_HZ = `CLK_HZ
) (
	input  wire logic        clk_sys_in,
	input  wire logic        rstn_in,
	input  wire logic        en_in,
	input  wire logic [16:0] freq_in,
	output logic             pulse_out,
	output logic             fall_out
);

	localparam logic [31:0] LIMIT = 32'(CLK_HZ);

	logic [31:0] acc_r;
	logic [31:0] acc_nxt;

	// Twice the frequency per cycle: each overflow is one half period
	assign acc_nxt = acc_r + {14'h0000, freq_in, 1'b0};

	always_ff @(posedge clk_sys_in)
	begin
		if (!rstn_in || !en_in)
		begin
			acc_r     <= 32'h00000000;
			pulse_out <= 1'b0;
			fall_out  <= 1'b0;
		end
		else if (acc_nxt >= LIMIT)
		begin
			acc_r     <= acc_nxt - LIMIT;
			pulse_out <= ~pulse_out;
			fall_out  <= pulse_out;
		end
		else
		begin
			acc_r    <= acc_nxt;
			fall_out <= 1'b0;
		end
	end

endmodule

//--- ramped_pulse_train_generator.sv
// Four-output ramped pulse train generator with register port, pause and mark logic
`timescale 1ns/100ps
`include "ramped_pulse_defines.svh"

module ramped_pulse_train_generator #(
	parameter int CLK_HZ = `CLK_HZ
) (
	input  wire logic        clk_sys_in,
	input  wire logic        rstn_in,
	input  wire logic [7:0]  addr_in,
	input  wire logic [15:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	input  wire logic        sensor_in_a,
	input  wire logic        sensor_in_b,
	output logic [15:0]      rdata_out,
	output logic             fast_out_a,
	output logic             slow_out_a,
	output logic             fast_out_b,
	output logic             slow_out_b
);

	localparam int CYC_PER_MS = CLK_HZ / 1000;

	logic [15:0] freq_lo_r [4];
	logic [15:0] freq_hi_r [4];
	logic [15:0] cnt_lo_r  [4];
	logic [15:0] cnt_hi_r  [4];
	logic [15:0] ramp_r    [4];
	logic        run_r     [4];
	logic        wide_r    [4];
	logic        pause_r   [4];
	logic [15:0] fmt_r     [2];
	logic [15:0] edge_r    [2];
	logic [15:0] down_t_r  [2];
	logic [15:0] mask_lo_r [2];
	logic [15:0] mask_hi_r [2];
	logic [15:0] mstop_lo_r[2];
	logic [15:0] mstop_hi_r[2];
	logic        split_r   [2];
	logic        mark_en_r [2];
	logic        done_r    [2];
	logic        mpaused_r [2];
	logic        scurve_r;

	logic [31:0] pres      [4];
	logic        busy      [4];
	logic        paused    [4];
	logic        nco_out   [4];
	logic        start_ev  [4];
	logic        done_ev   [4];
	logic        mark_hit  [4];
	logic        mpause_ev [4];
	logic        resume_ev [4];
	logic        dir_own   [2];
	logic        dir_val   [2];
	logic [1:0]  sens_s1_r;
	logic [1:0]  sens_s2_r;
	logic [1:0]  sens_s3_r;
	logic [1:0]  sens_rise;
	logic [15:0] rd_mux;

	function automatic logic [16:0] clampf(input logic [31:0] raw, input logic [16:0] fmax);
		if (raw < {15'h0000, `F_MIN})
			clampf = `F_MIN;
		else if (raw > {15'h0000, fmax})
			clampf = fmax;
		else
			clampf = raw[16:0];
	endfunction

	function automatic logic [16:0] ramp_freq(input logic [16:0] edge_f, input logic [16:0] tgt,
		input logic [4:0] k, input logic [4:0] n, input logic s);
		logic [39:0] num;
		logic [39:0] den;
		logic [39:0] kk;
		logic [39:0] nn;
		kk = {35'h0, k};
		nn = {35'h0, n};
		if (s)
		begin
			// Smoothstep 3k^2n - 2k^3 over n^3 gives gentle ends
			num = {23'h0, tgt - edge_f} * (40'h3 * kk * kk * nn - 40'h2 * kk * kk * kk);
			den = nn * nn * nn;
		end
		else
		begin
			num = {23'h0, tgt - edge_f} * kk;
			den = nn;
		end
		ramp_freq = edge_f + num[16:0] - num[16:0] + 17'(num / den);
	endfunction

	function automatic logic [31:0] down_est(input logic [16:0] edge_f, input logic [16:0] tgt,
		input logic [15:0] t);
		logic [47:0] prod;
		prod = ({31'h0, edge_f} + {31'h0, tgt}) * {32'h0, t};
		down_est = 32'(prod / {15'h0000, `MS_PER_S, 1'b0});
	endfunction

	function automatic logic [31:0] step_cycles(input logic [15:0] t, input logic [4:0] n);
		logic [47:0] prod;
		prod = {32'h0, t} * 48'(CYC_PER_MS);
		step_cycles = 32'(prod / {43'h0, n});
	endfunction

	function automatic logic [15:0] tmin(input logic [15:0] t);
		tmin = (t < `T_MIN) ? `T_MIN : t;
	endfunction

	always_ff @(posedge clk_sys_in)
	begin
		if (!rstn_in)
		begin
			sens_s1_r <= 2'h0;
			sens_s2_r <= 2'h0;
			sens_s3_r <= 2'h0;
		end
		else
		begin
			sens_s1_r <= {sensor_in_b, sensor_in_a};
			sens_s2_r <= sens_s1_r;
			sens_s3_r <= sens_s2_r;
		end
	end

	assign sens_rise = sens_s2_r & ~sens_s3_r;

	always_ff @(posedge clk_sys_in)
	begin
		if (!rstn_in)
		begin
			for (int i = 0; i < 4; i++)
			begin
				freq_lo_r[i] <= `REG_RESET;
				freq_hi_r[i] <= `REG_RESET;
				cnt_lo_r[i]  <= `REG_RESET;
				cnt_hi_r[i]  <= `REG_RESET;
				ramp_r[i]    <= `REG_RESET;
				run_r[i]     <= 1'b0;
				wide_r[i]    <= 1'b0;
				pause_r[i]   <= 1'b0;
			end
		end
		else
		begin
			for (int i = 0; i < 4; i++)
			begin
				if (wr_in && addr_in[7:6] == 2'h0 && addr_in[5:4] == 2'(i))
				begin
					case (addr_in[3:0])
						`OFS_FREQ_LO: freq_lo_r[i] <= wdata_in;
						`OFS_FREQ_HI: freq_hi_r[i] <= wdata_in;
						`OFS_CNT_LO:  cnt_lo_r[i]  <= wdata_in;
						`OFS_CNT_HI:  cnt_hi_r[i]  <= wdata_in;
						`OFS_RAMP:    ramp_r[i]    <= wdata_in;
						`OFS_CTRL:
						begin
							run_r[i]   <= wdata_in[`CTRL_RUN];
							wide_r[i]  <= wdata_in[`CTRL_WIDE];
							pause_r[i] <= wdata_in[`CTRL_PAUSE];
						end
						default: ;
					endcase
				end
				if (mark_hit[i])
					pause_r[i] <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (!rstn_in)
		begin
			for (int c = 0; c < 2; c++)
			begin
				fmt_r[c]      <= `REG_RESET;
				edge_r[c]     <= `REG_RESET;
				down_t_r[c]   <= `REG_RESET;
				mask_lo_r[c]  <= `REG_RESET;
				mask_hi_r[c]  <= `REG_RESET;
				mstop_lo_r[c] <= `REG_RESET;
				mstop_hi_r[c] <= `REG_RESET;
				split_r[c]    <= 1'b0;
				mark_en_r[c]  <= 1'b0;
			end
			scurve_r <= 1'b0;
		end
		else if (wr_in)
		begin
			for (int c = 0; c < 2; c++)
			begin
				if (addr_in[7:5] == `CH_BASE && addr_in[4] == 1'(c))
				begin
					case (addr_in[3:0])
						`OFS_FMT:      fmt_r[c]      <= wdata_in;
						`OFS_EDGE:     edge_r[c]     <= wdata_in;
						`OFS_DOWN_T:   down_t_r[c]   <= wdata_in;
						`OFS_MASK_LO:  mask_lo_r[c]  <= wdata_in;
						`OFS_MASK_HI:  mask_hi_r[c]  <= wdata_in;
						`OFS_MSTOP_LO: mstop_lo_r[c] <= wdata_in;
						`OFS_MSTOP_HI: mstop_hi_r[c] <= wdata_in;
						`OFS_CH_FLAGS:
						begin
							split_r[c]   <= wdata_in[`FLAG_SPLIT];
							mark_en_r[c] <= wdata_in[`FLAG_MARK_EN];
						end
						default: ;
					endcase
				end
			end
			if (addr_in == `ADDR_GLOBAL)
				scurve_r <= wdata_in[`GLB_SCURVE];
		end
	end

	// Status flags: a set in the same cycle as a clear wins
	always_ff @(posedge clk_sys_in)
	begin
		if (!rstn_in)
		begin
			for (int c = 0; c < 2; c++)
			begin
				done_r[c]    <= 1'b0;
				mpaused_r[c] <= 1'b0;
			end
		end
		else
		begin
			for (int c = 0; c < 2; c++)
			begin
				if (start_ev[2 * c])
					done_r[c] <= 1'b0;
				if (done_ev[2 * c])
					done_r[c] <= 1'b1;
				if (resume_ev[2 * c] || start_ev[2 * c])
					mpaused_r[c] <= 1'b0;
				if (mpause_ev[2 * c])
					mpaused_r[c] <= 1'b1;
			end
		end
	end

	for (genvar g = 0; g < 4; g++)
	begin : gen_op
		localparam bit FAST = (g % 2) == 0;
		localparam int CH = g / 2;
		localparam logic [4:0] NK = FAST ? `STEPS_FAST : `STEPS_SLOW;

		ramped_pulse_pkg::engine_state_t st;
		ramped_pulse_pkg::op_latch_t     lt;
		logic [4:0]  k;
		logic [31:0] tmr, tot, stop_at, dnp, dnp_norm;
		logic        run_q, pausing, mark_act, nco_fall;
		logic [31:0] raw_f, raw_c, mag, remain, stepc, est_mark, mstop, mask, half, mp;
		logic [16:0] fmax, tgt, edg, f_now;
		logic [15:0] tup, tdn_sel, dtm;
		logic        running, step_end, blocked, mark_ok, fin, plain_pause, start;

		assign raw_f = wide_r[g] ? {freq_hi_r[g], freq_lo_r[g]} : {16'h0000, freq_lo_r[g]};
		assign raw_c = wide_r[g] ? {cnt_hi_r[g], cnt_lo_r[g]} : {{16{cnt_lo_r[g][15]}}, cnt_lo_r[g]};
		assign mag   = raw_c[31] ? (~raw_c + 32'h00000001) : raw_c;
		assign fmax  = !FAST ? `F_MAX_SLOW : (wide_r[g] ? `F_MAX_FAST32 : `F_MAX_FAST16);
		assign tgt   = clampf(raw_f, fmax);
		assign edg   = FAST ? ((clampf({16'h0000, edge_r[CH]}, fmax) < tgt) ?
			clampf({16'h0000, edge_r[CH]}, fmax) : tgt) : 17'h00000;
		assign tup   = tmin(ramp_r[g]);
		assign dtm   = tmin(down_t_r[CH]);
		assign tdn_sel = (FAST && split_r[CH]) ? dtm : tup;

		assign running  = st != ramped_pulse_pkg::ST_IDLE;
		assign remain   = stop_at - pres[g];
		assign stepc    = step_cycles((st == ramped_pulse_pkg::ST_DOWN) ? lt.tdn : lt.tup, NK);
		assign step_end = (tmr + 32'h00000001) >= stepc;
		assign mstop    = {mstop_hi_r[CH], mstop_lo_r[CH]};
		assign mask     = {mask_hi_r[CH], mask_lo_r[CH]};
		assign est_mark = down_est(lt.edge_f, lt.tgt, dtm);
		assign half     = tot >> 1;
		// mark count fitted to down time and below half
		assign mp = ((mstop < est_mark ? est_mark : mstop) >= half) ?
			((half == 32'h0) ? 32'h0 : half - 32'h00000001) :
			(mstop < est_mark ? est_mark : mstop);
		// mark accepted only when enabled and unmasked
		assign mark_ok = FAST && mark_en_r[CH] && mstop != 32'h0 && sens_rise[CH] && !mark_act
			&& (st == ramped_pulse_pkg::ST_UP || st == ramped_pulse_pkg::ST_HOLD)
			&& !(mask != 32'h0 && pres[g] < mask) && run_r[g];
		assign plain_pause = pause_r[g] && !mark_act;
		// slow pin already carries direction for the first driver
		assign blocked  = !FAST && dir_own[CH];
		assign start    = !running && run_r[g] && !run_q && !blocked;
		assign fin      = running && run_r[g] && nco_fall && (pres[g] + 32'h00000001) >= stop_at;

		assign busy[g]      = running;
		assign paused[g]    = st == ramped_pulse_pkg::ST_PAUSED;
		assign start_ev[g]  = start;
		assign mark_hit[g]  = mark_ok;
		assign done_ev[g]   = FAST && lt.dir_fmt && fin && (pres[g] + 32'h00000001) >= tot;
		assign mpause_ev[g] = fin && mark_act && (pres[g] + 32'h00000001) < tot;
		assign resume_ev[g] = paused[g] && run_r[g] && !pause_r[g];

		if (FAST)
		begin : gen_dir
			assign dir_own[CH] = running && lt.dir_own;
			assign dir_val[CH] = lt.fwd;
		end

		always_comb
		begin
			case (st)
				ramped_pulse_pkg::ST_UP,
				ramped_pulse_pkg::ST_HOLD,
				ramped_pulse_pkg::ST_DOWN:
					f_now = ramp_freq(lt.edge_f, lt.tgt, k, NK, lt.s_curve);
				ramped_pulse_pkg::ST_FILL:
					f_now = lt.fill;
				default:
					f_now = 17'h00000;
			endcase
		end

		always_ff @(posedge clk_sys_in)
		begin
			if (!rstn_in)
			begin
				st       <= ramped_pulse_pkg::ST_IDLE;
				lt       <= '0;
				k        <= 5'h00;
				tmr      <= 32'h0;
				tot      <= 32'h0;
				stop_at  <= 32'h0;
				dnp      <= 32'h0;
				dnp_norm <= 32'h0;
				pres[g]  <= 32'h0;
				run_q    <= 1'b0;
				pausing  <= 1'b0;
				mark_act <= 1'b0;
			end
			else
			begin
				run_q <= run_r[g];
				if (start)
				begin
					lt.tgt     <= tgt;
					lt.edge_f  <= edg;
					lt.fill    <= (edg < `F_MIN) ? `F_MIN : edg;
					lt.tup     <= tup;
					lt.tdn     <= tdn_sel;
					// S curve only on fast outputs
					lt.s_curve <= FAST && scurve_r;
					lt.dir_fmt <= FAST && fmt_r[CH] == 16'h0001;
					lt.dir_own <= FAST && fmt_r[CH] == 16'h0001 && !busy[g | 1];
					lt.fwd     <= !raw_c[31];
					tot        <= mag;
					stop_at    <= mag;
					dnp        <= (down_est(edg, tgt, tdn_sel) > (mag >> 1)) ?
						(mag >> 1) : down_est(edg, tgt, tdn_sel);
					dnp_norm   <= (down_est(edg, tgt, tdn_sel) > (mag >> 1)) ?
						(mag >> 1) : down_est(edg, tgt, tdn_sel);
					k          <= 5'h01;
					tmr        <= 32'h0;
					pausing    <= 1'b0;
					mark_act   <= 1'b0;
					// continue from present count unless finished
					if (pres[g] >= mag)
						pres[g] <= 32'h0;
					st <= (mag == 32'h0) ? ramped_pulse_pkg::ST_IDLE : ramped_pulse_pkg::ST_UP;
				end
				else if (running && !run_r[g])
				begin
					st <= ramped_pulse_pkg::ST_IDLE;
				end
				else if (running)
				begin
					case (st)
						ramped_pulse_pkg::ST_UP,
						ramped_pulse_pkg::ST_HOLD:
						begin
							if (remain <= dnp || plain_pause)
							begin
								st      <= ramped_pulse_pkg::ST_DOWN;
								tmr     <= 32'h0;
								pausing <= plain_pause;
							end
							else if (st == ramped_pulse_pkg::ST_UP && step_end)
							begin
								tmr <= 32'h0;
								k   <= k + 5'h01;
								if (k + 5'h01 == NK)
									st <= ramped_pulse_pkg::ST_HOLD;
							end
							else
								tmr <= tmr + 32'h00000001;
						end
						ramped_pulse_pkg::ST_DOWN:
						begin
							if (plain_pause)
								pausing <= 1'b1;
							if (step_end)
							begin
								tmr <= 32'h0;
								if (k <= 5'h01)
								begin
									k  <= 5'h00;
									st <= (pausing || plain_pause) ? ramped_pulse_pkg::ST_PAUSED :
										ramped_pulse_pkg::ST_FILL;
								end
								else
									k <= k - 5'h01;
							end
							else
								tmr <= tmr + 32'h00000001;
						end
						ramped_pulse_pkg::ST_FILL:
						begin
							if (plain_pause)
								st <= ramped_pulse_pkg::ST_PAUSED;
						end
						ramped_pulse_pkg::ST_PAUSED:
						begin
							if (!pause_r[g])
							begin
								st       <= ramped_pulse_pkg::ST_UP;
								k        <= 5'h01;
								tmr      <= 32'h0;
								stop_at  <= tot;
								dnp      <= dnp_norm;
								lt.tdn   <= tdn_sel;
								pausing  <= 1'b0;
								mark_act <= 1'b0;
							end
						end
						default:
							st <= ramped_pulse_pkg::ST_IDLE;
					endcase
					// mark ramp-down with its own time
					if (mark_ok)
					begin
						mark_act <= 1'b1;
						stop_at  <= pres[g] + mp;
						dnp      <= est_mark;
						lt.tdn   <= dtm;
					end
					if (nco_fall && st != ramped_pulse_pkg::ST_PAUSED)
						pres[g] <= pres[g] + 32'h00000001;
					// fill runs until the exact count is out
					if (fin)
						st <= mpause_ev[g] ? ramped_pulse_pkg::ST_PAUSED : ramped_pulse_pkg::ST_IDLE;
				end
			end
		end

		pulse_nco #(
			.CLK_HZ (CLK_HZ)
		) u_nco (
			.clk_sys_in (clk_sys_in),
			.rstn_in    (rstn_in),
			.en_in      (run_r[g] && running && !paused[g]),
			.freq_in    (f_now),
			.pulse_out  (nco_out[g]),
			.fall_out   (nco_fall)
		);
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (!rstn_in)
		begin
			fast_out_a <= 1'b0;
			slow_out_a <= 1'b0;
			fast_out_b <= 1'b0;
			slow_out_b <= 1'b0;
		end
		else
		begin
			fast_out_a <= nco_out[0];
			fast_out_b <= nco_out[2];
			// slow pin carries direction in format one
			slow_out_a <= dir_own[0] ? dir_val[0] : nco_out[1];
			slow_out_b <= dir_own[1] ? dir_val[1] : nco_out[3];
		end
	end

	always_comb
	begin
		rd_mux = 16'h0000;
		if (addr_in[7:6] == 2'h0)
		begin
			case (addr_in[3:0])
				`OFS_FREQ_LO: rd_mux = freq_lo_r[addr_in[5:4]];
				`OFS_FREQ_HI: rd_mux = freq_hi_r[addr_in[5:4]];
				`OFS_CNT_LO:  rd_mux = cnt_lo_r[addr_in[5:4]];
				`OFS_CNT_HI:  rd_mux = cnt_hi_r[addr_in[5:4]];
				`OFS_RAMP:    rd_mux = ramp_r[addr_in[5:4]];
				`OFS_CTRL:    rd_mux = {13'h0000, pause_r[addr_in[5:4]], wide_r[addr_in[5:4]],
					run_r[addr_in[5:4]]};
				`OFS_PRES_LO: rd_mux = pres[addr_in[5:4]][15:0];
				`OFS_PRES_HI: rd_mux = pres[addr_in[5:4]][31:16];
				`OFS_STAT:    rd_mux = {13'h0000, addr_in[4] ? 1'b0 : dir_val[addr_in[5]],
					paused[addr_in[5:4]], busy[addr_in[5:4]]};
				default:      rd_mux = 16'h0000;
			endcase
		end
		else if (addr_in[7:5] == `CH_BASE)
		begin
			case (addr_in[3:0])
				`OFS_FMT:      rd_mux = fmt_r[addr_in[4]];
				`OFS_EDGE:     rd_mux = edge_r[addr_in[4]];
				`OFS_DOWN_T:   rd_mux = down_t_r[addr_in[4]];
				`OFS_MASK_LO:  rd_mux = mask_lo_r[addr_in[4]];
				`OFS_MASK_HI:  rd_mux = mask_hi_r[addr_in[4]];
				`OFS_MSTOP_LO: rd_mux = mstop_lo_r[addr_in[4]];
				`OFS_MSTOP_HI: rd_mux = mstop_hi_r[addr_in[4]];
				`OFS_CH_FLAGS: rd_mux = {14'h0000, mark_en_r[addr_in[4]], split_r[addr_in[4]]};
				`OFS_CH_STAT:  rd_mux = {14'h0000, mpaused_r[addr_in[4]], done_r[addr_in[4]]};
				default:       rd_mux = 16'h0000;
			endcase
		end
		else if (addr_in == `ADDR_GLOBAL)
			rd_mux = {15'h0000, scurve_r};
	end

	// Read data stand for exactly one cycle, zero otherwise
	always_ff @(posedge clk_sys_in)
	begin
		if (!rstn_in)
			rdata_out <= 16'h0000;
		else
			rdata_out <= rd_in ? rd_mux : 16'h0000;
	end

endmodule

//--- ramped_pulse_monitor.sv
// Port checker for the ramped pulse train generator
`timescale 1ns/100ps
module ramped_pulse_monitor #(
	parameter int CLK_HZ = 40000000
) (
	input logic        clk_sys_in,
	input logic        rstn_in,
	input logic [7:0]  addr_in,
	input logic [15:0] wdata_in,
	input logic        wr_in,
	input logic        rd_in,
	input logic        sensor_in_a,
	input logic        sensor_in_b,
	input logic [15:0] rdata_out,
	input logic        fast_out_a,
	input logic        slow_out_a,
	input logic        fast_out_b,
	input logic        slow_out_b
);
	default clocking @(posedge clk_sys_in);
	endclocking
	default disable iff (!rstn_in);
	AST_RESET_QUIET: assert property (disable iff (1'b0)
		!rstn_in |=> {fast_out_a, slow_out_a, fast_out_b, slow_out_b, rdata_out} == 20'h00000)
		else $error("outputs active after reset");
	AST_STOP_A: assert property (wr_in && addr_in == 8'h05 && !wdata_in[0]
		|=> ##2 (!$rose(fast_out_a)) [*6])
		else $error("fast_out_a pulsed after stop");
	AST_STOP_B: assert property (wr_in && addr_in == 8'h25 && !wdata_in[0]
		|=> ##2 (!$rose(fast_out_b)) [*6])
		else $error("fast_out_b pulsed after stop");
	AST_RD_ONE_CYCLE: assert property (!rd_in |=> rdata_out == 16'h0000)
		else $error("read data outside its cycle");
	AST_RD_UNMAPPED: assert property (rd_in && (addr_in > 8'h60 || addr_in[3:0] > 4'h8)
		|=> rdata_out == 16'h0000)
		else $error("unmapped read not zero");
	// Valid for timebases of 40 kHz and up: the 10 kHz ceiling is two cycles high, two low
	AST_SLOW_HIGH: assert property ($rose(slow_out_a) |=> slow_out_a)
		else $error("slow pulse high too short");
	AST_SLOW_LOW: assert property ($fell(slow_out_a) |=> !slow_out_a)
		else $error("slow pulse low too short");
	AST_SLOW_START: assert property (wr_in && addr_in == 8'h15 && wdata_in[0]
		|=> (!$rose(slow_out_a)) [*2])
		else $error("slow output started above zero rate");
endmodule
bind ramped_pulse_train_generator ramped_pulse_monitor #(.CLK_HZ(CLK_HZ)) mon_u (
	.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
	.wr_in(wr_in), .rd_in(rd_in), .sensor_in_a(sensor_in_a), .sensor_in_b(sensor_in_b),
	.rdata_out(rdata_out), .fast_out_a(fast_out_a), .slow_out_a(slow_out_a),
	.fast_out_b(fast_out_b), .slow_out_b(slow_out_b));

//--- drive_model.sv
// Step and direction drive that tracks the axis position it is commanded to
`timescale 1ns/100ps
module drive_model (
	input  wire logic          clk_sys_in,
	input  wire logic          rstn_in,
	input  wire logic          step_in,
	input  wire logic          dir_in,
	input  wire logic          dir_mode_in,
	output logic signed [31:0] pos_out
);
	logic step_r;
	always_ff @(posedge clk_sys_in)
	begin
		step_r <= step_in;
		if (!rstn_in)
			pos_out <= 32'sh0;
		else if (step_in && !step_r)
			pos_out <= (dir_mode_in && !dir_in) ? pos_out - 1 : pos_out + 1;
	end
endmodule

//--- ramped_pulse_train_generator_test.sv
// Self-checking bench for the ramped pulse train generator
`timescale 1ns/100ps
`include "ramped_pulse_defines.svh"
module ramped_pulse_train_generator_test;
	logic               clk_sys_in = 1'b0;
	logic               rstn_in = 1'b0;
	logic [7:0]         addr_in = 8'h00;
	logic [15:0]        wdata_in = 16'h0000;
	logic               wr_in = 1'b0;
	logic               rd_in = 1'b0;
	logic               dir_mode = 1'b0;
	logic               sens_a = 1'b0;
	logic               sens_b = 1'b0;
	logic [15:0]        rdata_out;
	logic               fast_out_a;
	logic               slow_out_a;
	logic               fast_out_b;
	logic               slow_out_b;
	logic signed [31:0] pos_a;
	logic signed [31:0] pos_s;
	logic signed [31:0] pos_b;
	logic [15:0]        v;
	int                 failures = 0;
	int                 n_compared = 0;
	always #12.5 clk_sys_in = ~clk_sys_in;
	// Short timebase keeps pulse periods to tens of cycles
	ramped_pulse_train_generator #(.CLK_HZ(40000)) dut_u (
		.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .sensor_in_a(sens_a), .sensor_in_b(sens_b),
		.rdata_out(rdata_out), .fast_out_a(fast_out_a), .slow_out_a(slow_out_a),
		.fast_out_b(fast_out_b), .slow_out_b(slow_out_b));
	drive_model drv_a (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .step_in(fast_out_a),
		.dir_in(slow_out_a), .dir_mode_in(dir_mode), .pos_out(pos_a));
	drive_model drv_s (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .step_in(slow_out_a),
		.dir_in(1'b1), .dir_mode_in(1'b0), .pos_out(pos_s));
	drive_model drv_b (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .step_in(fast_out_b),
		.dir_in(1'b1), .dir_mode_in(1'b0), .pos_out(pos_b));
	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
		@(posedge clk_sys_in);
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_sys_in);
		rd_in <= 1'b0;
		@(negedge clk_sys_in);
		d = rdata_out;
		@(posedge clk_sys_in);
	endtask
	task automatic launch(input logic [7:0] b, input logic [15:0] f, input logic [15:0] c);
		wr(b + `OFS_FREQ_LO, f);
		wr(b + `OFS_CNT_LO, c);
		wr(b + `OFS_RAMP, `T_MIN);
		wr(b + `OFS_CTRL, 16'h0001);
	endtask
	task automatic wait_idle(input logic [7:0] b);
		int k;
		v = 16'h0001;
		for (k = 0; k < 30000 && v[0] !== 1'b0; k++)
			rd(b + `OFS_STAT, v);
		check("busy", {31'h0, v[0]}, 32'h0);
	endtask
	task automatic t_regs;
		int i;
		rd(8'h41, v);
		check("edge_rst", {16'h0, v}, {16'h0, `REG_RESET});
		for (i = 0; i < 12; i++)
			wr(8'h41 + 8'(i / 6 * 16 + i % 6), 16'h0100 + 16'(i));
		for (i = 0; i < 12; i++)
		begin
			rd(8'h41 + 8'(i / 6 * 16 + i % 6), v);
			check("ch_reg", {16'h0, v}, 32'h100 + i);
		end
		rd(8'h7F, v);
		check("unmapped", {16'h0, v}, 32'h0);
	endtask
	task automatic t_count;
		// sensor edge ignored while mark is off
		sens_a <= 1'b1;
		launch(8'h00, 16'h03E8, 16'h000A);
		wr(8'h02, 16'h0063);
		wait_idle(8'h00);
		check("pos_a", pos_a, 32'd10);
		check("slow_quiet", pos_s, 32'd0);
		rd(8'h06, v);
		check("present", {16'h0, v}, 32'd10);
		sens_a <= 1'b0;
		wr(8'h05, 16'h0000);
	endtask
	task automatic t_dir;
		dir_mode <= 1'b1;
		wr(8'h40, 16'h0001);
		launch(8'h00, 16'h03E8, 16'hFFF6);
		wait_idle(8'h00);
		check("pos_rev", pos_a, 32'd0);
		rd(8'h48, v);
		check("done", {16'h0, v}, 32'h1);
		wr(8'h05, 16'h0000);
		wr(8'h05, 16'h0001);
		rd(8'h48, v);
		check("done_clr", {16'h0, v}, 32'h0);
		check("dir_pin", {31'h0, slow_out_a}, 32'h0);
		wait_idle(8'h00);
		check("pos_rev2", pos_a, 32'hFFFFFFF6);
		wr(8'h05, 16'h0000);
		wr(8'h40, 16'h0000);
		dir_mode <= 1'b0;
	endtask
	task automatic t_stop;
		logic signed [31:0] p;
		int k;
		launch(8'h20, 16'h03E8, 16'h001E);
		// Stop in a low phase so that no pulse is cut short
		for (k = 0; k < 5000 && (pos_b < 5 || fast_out_b); k++)
			@(posedge clk_sys_in);
		wr(8'h25, 16'h0000);
		@(posedge clk_sys_in);
		p = pos_b;
		repeat (400) @(posedge clk_sys_in);
		check("halt", pos_b, p);
		wr(8'h25, 16'h0001);
		wait_idle(8'h20);
		check("resume", pos_b, 32'd30);
		wr(8'h25, 16'h0000);
	endtask
	task automatic t_mark;
		int k;
		// mark down time of 263 ms stays from the register test
		wr(8'h50, 16'h0001);
		wr(8'h53, 16'h0000);
		wr(8'h54, 16'h0000);
		wr(8'h57, 16'h0002);
		launch(8'h20, 16'h03E8, 16'h001E);
		for (k = 0; k < 5000 && pos_b < 33; k++)
			@(posedge clk_sys_in);
		sens_b <= 1'b1;
		v = 16'h0000;
		for (k = 0; k < 9000 && v[1] !== 1'b1; k++)
			rd(8'h28, v);
		check("mark_stop", pos_b, 32'd46);
		check("dir_b", {31'h0, slow_out_b}, 32'h1);
		rd(8'h58, v);
		check("mark_flag", {16'h0, v}, 32'h2);
		rd(8'h25, v);
		check("pause_set", {16'h0, v}, 32'h5);
		sens_b <= 1'b0;
		wr(8'h25, 16'h0001);
		wait_idle(8'h20);
		check("mark_rest", pos_b, 32'd60);
		wr(8'h25, 16'h0000);
	endtask
	task automatic t_slow;
		launch(8'h10, 16'h4E20, 16'h0028);
		wait_idle(8'h10);
		check("pos_s", pos_s, 32'd40);
		wr(8'h15, 16'h0000);
	endtask
	task automatic complete_run;
		if (failures == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (8) @(posedge clk_sys_in);
		rstn_in <= 1'b1;
		@(posedge clk_sys_in);
		t_regs();
		t_count();
		t_dir();
		t_stop();
		t_mark();
		t_slow();
		complete_run();
	end
	initial
	begin
		repeat (99000) @(posedge clk_sys_in);
		failures++;
		complete_run();
	end
endmodule
